// ---- epm_params.svh ----
`ifndef EPM_PARAMS_SVH
`define EPM_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define EPM_IDX_CRC4_LO 6'h00
`define EPM_IDX_CRC4_HI 6'h01
`define EPM_IDX_ALIGN_LO 6'h02
`define EPM_IDX_ALIGN_HI 6'h03
`define EPM_IDX_CHANGE 6'h04
`define EPM_IDX_LOSS 6'h05
`define EPM_IDX_PATTERN_LO 6'h06
`define EPM_IDX_PATTERN_HI 6'h07
`define EPM_IDX_LCV_LO 6'h08
`define EPM_IDX_LCV_HI 6'h09
`define EPM_IDX_NETCRC_LO 6'h0A
`define EPM_IDX_NETCRC_HI 6'h0B
`define EPM_IDX_REMOTE_LO 6'h0C
`define EPM_IDX_REMOTE_HI 6'h0D
`define EPM_IDX_CTRL 6'h10
`define EPM_IDX_STAT 6'h11

// ==========================================================
// fields and reset values
`define EPM_CTRL_AUTO_BIT 0
`define EPM_CTRL_TRIG_BIT 1
`define EPM_CTRL_RESET 2'h0
`define EPM_HI10_LSB 4
`define EPM_STAT_AUTO_BIT 8

// ==========================================================
// counter widths
`define EPM_W_CRC4 10
`define EPM_W_ALIGN 11
`define EPM_W_CHANGE 3
`define EPM_W_LOSS 5
`define EPM_W_PATTERN 16
`define EPM_W_LCV 16
`define EPM_W_NETCRC 10
`define EPM_W_REMOTE 10
`define EPM_NUM_CNT 8

// ==========================================================
// timing
`define EPM_CLK_PERIOD_NS 100
`define EPM_REFRESH_PERIOD_NS 1000000000
`define EPM_REFRESH_CYCLES (`EPM_REFRESH_PERIOD_NS / `EPM_CLK_PERIOD_NS)

// ==========================================================
// bus answers
`define EPM_RESP_OKAY 2'h0
`define EPM_RESP_SLVERR 2'h2

`endif

// ---- epm_pkg.sv ----
package epm_pkg;

   // one-cycle event pulses from the framer and detectors
   typedef struct packed {
      logic remoteBlockError;
      logic networkSideCrcError;
      logic lineCodeViolation;
      logic patternDetectorError;
      logic frameLoss;
      logic alignmentChange;
      logic alignmentError;
      logic crc4Error;
   } epm_events_t;

   // what started a group refresh
   typedef struct packed {
      logic manual;
      logic auto;
   } epm_refresh_cause_t;

endpackage

// ---- epm_perf_monitor.sv ----
`timescale 1ns/1ps
`include "epm_params.svh"

module epm_perf_monitor #(
   parameter int ADDR_W = 8,
   parameter int REFRESH_CYCLES = `EPM_REFRESH_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // counted events, same clock
   input epm_pkg::epm_events_t events,
   // refresh indication
   output logic refreshStrobe,
   output epm_pkg::epm_refresh_cause_t refreshCause,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   import epm_pkg::*;

   // ==========================================================
   // elaboration checks
   localparam int IDX_W = ADDR_W - 2;

   // control and status sit above the bank, so seven address bits are the floor
   if (ADDR_W < 7 || ADDR_W > 32)
   begin : gBadAddrW
      $error("address width must hold the control and status words");
   end

   // a one-cycle period would tick on every clock
   if (REFRESH_CYCLES < 2)
   begin : gBadRefresh
      $error("refresh period must be at least two cycles");
   end

   // ==========================================================
   // event vector, index 0 is the crc-4 counter
   localparam int CNT_W [`EPM_NUM_CNT] = '{
      `EPM_W_CRC4, `EPM_W_ALIGN, `EPM_W_CHANGE, `EPM_W_LOSS,
      `EPM_W_PATTERN, `EPM_W_LCV, `EPM_W_NETCRC, `EPM_W_REMOTE
   };

   wire logic [`EPM_NUM_CNT-1:0] evVec;

   assign evVec = {
      events.remoteBlockError,
      events.networkSideCrcError,
      events.lineCodeViolation,
      events.patternDetectorError,
      events.frameLoss,
      events.alignmentChange,
      events.alignmentError,
      events.crc4Error
   };

   // ==========================================================
   // control and refresh timing
   logic [1:0] ctrl_q;
   logic trigPrev_q;
   logic [31:0] secCnt_q;
   logic [31:0] secCnt_d;
   logic [7:0] refreshCount_q;
   logic refreshStrobe_q;
   epm_refresh_cause_t refreshCause_q;

   wire logic autoEnable;
   wire logic manualEdge;
   wire logic autoTick;
   wire logic refreshPulse;

   assign autoEnable = ctrl_q[`EPM_CTRL_AUTO_BIT];
   assign manualEdge = ctrl_q[`EPM_CTRL_TRIG_BIT] & ~trigPrev_q;
   assign autoTick = autoEnable && (secCnt_q == 32'(REFRESH_CYCLES - 1));
   // one pulse serves both causes so the group never refreshes twice
   assign refreshPulse = manualEdge | autoTick;

   // seconds timer idles at zero while auto refresh is off
   assign secCnt_d = !autoEnable ? 32'h0 :
                     autoTick ? 32'h0 :
                     secCnt_q + 32'h1;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         trigPrev_q <= 1'b0;
         secCnt_q <= 32'h0;
      end
      else
      begin
         trigPrev_q <= ctrl_q[`EPM_CTRL_TRIG_BIT];
         secCnt_q <= secCnt_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         refreshCount_q <= 8'h00;
         refreshStrobe_q <= 1'b0;
         refreshCause_q <= '0;
      end
      else
      begin
         refreshStrobe_q <= refreshPulse;
         refreshCause_q <= '{manual: manualEdge, auto: autoTick};
         if (refreshPulse)
            refreshCount_q <= refreshCount_q + 8'h01;
      end
   end

   assign refreshStrobe = refreshStrobe_q;
   assign refreshCause = refreshCause_q;

   // ==========================================================
   // running counters and snapshot bank
   logic [15:0] run_q [`EPM_NUM_CNT];
   logic [15:0] snap_q [`EPM_NUM_CNT];

   for (genvar i = 0; i < `EPM_NUM_CNT; i++)
   begin : gCnt
      localparam logic [15:0] MAXV = 16'((32'h1 << CNT_W[i]) - 32'h1);
      wire logic atMax;
      wire logic [15:0] runD;

      // counts saturate rather than wrap so an overflow never reads small
      assign atMax = run_q[i] == MAXV;
      // an event in the refresh cycle starts the next interval
      assign runD = refreshPulse ? {15'h0, evVec[i]} :
                    (evVec[i] && !atMax) ? run_q[i] + 16'h1 :
                    run_q[i];

      always_ff @(posedge mclk or posedge sys_rst)
      begin
         if (sys_rst)
            run_q[i] <= 16'h0;
         else
            run_q[i] <= runD;
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
         if (sys_rst)
            snap_q[i] <= 16'h0;
         else if (refreshPulse)
            snap_q[i] <= run_q[i];
      end
   end

   // ==========================================================
   // counter register images
   wire logic [7:0] crc4Lo;
   wire logic [7:0] crc4Hi;
   wire logic [7:0] alignLo;
   wire logic [7:0] alignHi;
   wire logic [7:0] changeReg;
   wire logic [7:0] lossReg;
   wire logic [7:0] patternLo;
   wire logic [7:0] patternHi;
   wire logic [7:0] lcvLo;
   wire logic [7:0] lcvHi;
   wire logic [7:0] netCrcLo;
   wire logic [7:0] netCrcHi;
   wire logic [7:0] remoteLo;
   wire logic [7:0] remoteHi;

   assign crc4Lo = snap_q[0][7:0];
   assign crc4Hi = 8'({snap_q[0][9:8], 4'h0});
   assign alignLo = snap_q[1][7:0];
   assign alignHi = {5'h00, snap_q[1][10:8]};
   assign changeReg = {5'h00, snap_q[2][2:0]};
   assign lossReg = {3'h0, snap_q[3][4:0]};
   assign patternLo = snap_q[4][7:0];
   assign patternHi = snap_q[4][15:8];
   assign lcvLo = snap_q[5][7:0];
   assign lcvHi = snap_q[5][15:8];
   assign netCrcLo = snap_q[6][7:0];
   assign netCrcHi = 8'({snap_q[6][9:8], 4'h0});
   assign remoteLo = snap_q[7][7:0];
   assign remoteHi = 8'({snap_q[7][9:8], 4'h0});

   // ==========================================================
   // read decode
   wire logic [IDX_W-1:0] rdIdx;
   wire logic rdBank;
   wire logic rdCtrl;
   wire logic rdStat;
   wire logic rdHit;
   wire logic [7:0] bankByte;
   wire logic [31:0] rdWord;
   wire logic [31:0] statWord;

   assign rdIdx = s_axi_araddr[ADDR_W-1:2];
   assign rdBank = rdIdx <= IDX_W'(`EPM_IDX_REMOTE_HI);
   assign rdCtrl = rdIdx == IDX_W'(`EPM_IDX_CTRL);
   assign rdStat = rdIdx == IDX_W'(`EPM_IDX_STAT);
   assign rdHit = rdBank | rdCtrl | rdStat;

   assign bankByte =
      (rdIdx == IDX_W'(`EPM_IDX_CRC4_LO)) ? crc4Lo :
      (rdIdx == IDX_W'(`EPM_IDX_CRC4_HI)) ? crc4Hi :
      (rdIdx == IDX_W'(`EPM_IDX_ALIGN_LO)) ? alignLo :
      (rdIdx == IDX_W'(`EPM_IDX_ALIGN_HI)) ? alignHi :
      (rdIdx == IDX_W'(`EPM_IDX_CHANGE)) ? changeReg :
      (rdIdx == IDX_W'(`EPM_IDX_LOSS)) ? lossReg :
      (rdIdx == IDX_W'(`EPM_IDX_PATTERN_LO)) ? patternLo :
      (rdIdx == IDX_W'(`EPM_IDX_PATTERN_HI)) ? patternHi :
      (rdIdx == IDX_W'(`EPM_IDX_LCV_LO)) ? lcvLo :
      (rdIdx == IDX_W'(`EPM_IDX_LCV_HI)) ? lcvHi :
      (rdIdx == IDX_W'(`EPM_IDX_NETCRC_LO)) ? netCrcLo :
      (rdIdx == IDX_W'(`EPM_IDX_NETCRC_HI)) ? netCrcHi :
      (rdIdx == IDX_W'(`EPM_IDX_REMOTE_LO)) ? remoteLo :
      remoteHi;

   // count wraps; software compares two reads to see that a refresh happened
   assign statWord = 32'({autoEnable, refreshCount_q});

   assign rdWord = rdBank ? {24'h000000, bankByte} :
                   rdCtrl ? {30'h0, ctrl_q} :
                   rdStat ? statWord :
                   32'h0;

   // ==========================================================
   // read channel
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   wire logic arTake;

   // one read in flight; no new address while an answer stands
   assign s_axi_arready = !rvalid_q;
   assign arTake = s_axi_arvalid && !rvalid_q;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `EPM_RESP_OKAY;
      end
      else if (arTake)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rdWord;
         rresp_q <= rdHit ? `EPM_RESP_OKAY : `EPM_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ==========================================================
   // write channels, address and data taken in either order
   logic awHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic wHeld_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   wire logic awTake;
   wire logic wTake;
   wire logic wrCommit;
   wire logic [IDX_W-1:0] wrIdx;
   wire logic wrCtrl;
   wire logic wrHit;

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;
   assign awTake = s_axi_awvalid && !awHeld_q;
   assign wTake = s_axi_wvalid && !wHeld_q;
   // the response slot must be free before the next write lands
   assign wrCommit = awHeld_q && wHeld_q && !bvalid_q;
   assign wrIdx = awAddr_q[ADDR_W-1:2];
   assign wrCtrl = wrIdx == IDX_W'(`EPM_IDX_CTRL);
   // writes to read-only words are accepted and dropped
   assign wrHit = wrCtrl || wrIdx == IDX_W'(`EPM_IDX_STAT) ||
                  wrIdx <= IDX_W'(`EPM_IDX_REMOTE_HI);

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end
      else if (awTake)
      begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end
      else if (wrCommit)
         awHeld_q <= 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
      end
      else if (wTake)
      begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end
      else if (wrCommit)
         wHeld_q <= 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= `EPM_RESP_OKAY;
      end
      else if (wrCommit)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wrHit ? `EPM_RESP_OKAY : `EPM_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // control bits live in byte lane 0
   // trigger stays set until software clears it; only its rising edge counts
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         ctrl_q <= `EPM_CTRL_RESET;
      else if (wrCommit && wrCtrl && wStrb_q[0])
         ctrl_q <= wData_q[1:0];
   end

   // a master that never raises bready stalls all later writes
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

endmodule

// ---- epm_perf_monitor_props.sv ----
`timescale 1ns/1ps
// ==========
// refresh and bus checks seen at the ports
module epm_perf_monitor_props #(
   parameter int ADDR_W = 8,
   parameter int REFRESH_CYCLES = 20
) (
   // clock, reset, refresh
   input wire logic mclk,
   input wire logic sys_rst,
   input epm_pkg::epm_events_t events,
   input wire logic refreshStrobe,
   input epm_pkg::epm_refresh_cause_t refreshCause,
   // axi4-lite
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   import epm_pkg::*;
   logic [31:0] autoGap_q;
   logic autoSeen_q;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // ==========
   // cycles since the last timed refresh; wide enough for the full one-second period
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         autoGap_q <= 32'h0;
         autoSeen_q <= 1'b0;
      end
      else if (refreshStrobe && refreshCause.auto)
      begin
         autoGap_q <= 32'h1;
         autoSeen_q <= 1'b1;
      end
      else if (autoGap_q != 32'hFFFFFFFF)
         autoGap_q <= autoGap_q + 32'h1;
   end
   // ==========
   // properties
   property p_cause;
      refreshStrobe |-> (refreshCause.manual || refreshCause.auto);
   endproperty
   a_cause: assert property (p_cause) else $error("refresh without cause");
   property p_manual_once;
      refreshStrobe && refreshCause.manual |=> !(refreshStrobe && refreshCause.manual);
   endproperty
   a_manual_once: assert property (p_manual_once) else $error("double manual refresh");
   property p_auto_gap;
      refreshStrobe && refreshCause.auto && autoSeen_q |-> autoGap_q >= REFRESH_CYCLES;
   endproperty
   a_auto_gap: assert property (p_auto_gap) else $error("timed refresh too early");
   property p_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read upper bits set");
   property p_rstand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rstand: assert property (p_rstand) else $error("read data dropped");
   property p_arready;
      s_axi_arready == !s_axi_rvalid;
   endproperty
   a_arready: assert property (p_arready) else $error("arready wrong");
   property p_rafter;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rafter: assert property (p_rafter) else $error("read answer late");
   property p_bafter;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_bafter: assert property (p_bafter) else $error("write answer timing");
   property p_reset;
      $fell(sys_rst) |-> !s_axi_rvalid && !s_axi_bvalid && !refreshStrobe;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs busy after reset");
   c_manual: cover property (refreshStrobe && refreshCause.manual);
   c_auto: cover property (refreshStrobe && refreshCause.auto);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind epm_perf_monitor epm_perf_monitor_props #(
   .ADDR_W(ADDR_W),
   .REFRESH_CYCLES(REFRESH_CYCLES)
) epm_perf_monitor_props_inst (.*);

// ---- tb_epm_perf_monitor.sv ----
`timescale 1ns/1ps
`include "epm_params.svh"
module tb_epm_perf_monitor;
   import epm_pkg::*;
   localparam int RC = 20;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   epm_events_t events = '0;
   logic refreshStrobe;
   epm_refresh_cause_t refreshCause;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_total = 0, checks = 0;
   int wid [8] = '{`EPM_W_CRC4, `EPM_W_ALIGN, `EPM_W_CHANGE, `EPM_W_LOSS,
      `EPM_W_PATTERN, `EPM_W_LCV, `EPM_W_NETCRC, `EPM_W_REMOTE};
   int cix [14] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 6, 7, 7};
   always #50 mclk = ~mclk;
   epm_perf_monitor #(.ADDR_W(8), .REFRESH_CYCLES(RC)) epm_perf_monitor_inst (.*);
   // ==========
   // checking and closing
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #2000000;
      err_total++;
      results();
   end
   // ==========
   // bus tasks; ready and answers taken at the rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic b;
      int n;
      n = 0;
      b = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (b !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            b = 1'b1;
            r = s_axi_bresp;
         end
         n++;
      end
      s_axi_bready <= 1'b0;
      chk("bvalid", {31'h0, b}, 32'h1);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic v;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      v = 1'b0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (v !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            v = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
         n++;
      end
      s_axi_rready <= 1'b0;
      chk($sformatf("rdata %h", a), d, e);
      chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, er});
   endtask
   // ==========
   // counter bank helpers
   function automatic logic [7:0] bankByte(input int r, input int v [8]);
      logic [15:0] x;
      x = 16'(v[cix[r]]);
      case (r)
         1, 11, 13: return {2'h0, x[9:8], 4'h0};
         3: return {5'h0, x[10:8]};
         7, 9: return x[15:8];
         default: return x[7:0];
      endcase
   endfunction
   task automatic bank(input int v [8]);
      for (int r = 0; r < 14; r++)
         rc(8'(4 * r), {24'h0, bankByte(r, v)}, 2'h0);
   endtask
   task automatic drive(input int c [8]);
      int m;
      epm_events_t e;
      m = 0;
      for (int i = 0; i < 8; i++)
         m = (c[i] > m) ? c[i] : m;
      for (int k = 0; k < m; k++)
      begin
         for (int i = 0; i < 8; i++)
            e[i] = (k < c[i]);
         @(posedge mclk);
         events <= e;
      end
      @(posedge mclk);
      events <= '0;
   endtask
   task automatic waitStrobe(output int n);
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (refreshStrobe !== 1'b1 && n < 1000);
   endtask
   // ==========
   // main sequence
   initial
   begin
      int cnt [8];
      int sat [8];
      int zero [8];
      int n;
      logic [1:0] r;
      cnt = '{300, 1029, 9, 40, 4660, 258, 677, 1030};
      zero = '{0, 0, 0, 0, 0, 0, 0, 0};
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rc(8'h38, 32'h0, 2'h2);
      wr(8'h3C, 32'hFF, r);
      chk("bresp unmapped", {30'h0, r}, 32'h2);
      wr(8'h00, 32'hFF, r);
      chk("bresp bank", {30'h0, r}, 32'h0);
      bank(zero);
      rc(8'h40, 32'h0, 2'h0);
      drive(cnt);
      bank(zero);
      wr(8'h40, 32'h2, r);
      waitStrobe(n);
      chk("cause manual", {30'h0, refreshCause}, 32'h2);
      for (int i = 0; i < 8; i++)
         sat[i] = (cnt[i] > 2 ** wid[i] - 1) ? 2 ** wid[i] - 1 : cnt[i];
      bank(sat);
      drive('{3, 0, 0, 0, 0, 0, 0, 1});
      wr(8'h40, 32'h0, r);
      wr(8'h40, 32'h2, r);
      waitStrobe(n);
      bank('{3, 0, 0, 0, 0, 0, 0, 1});
      wr(8'h40, 32'h1, r);
      drive('{4, 0, 0, 0, 0, 0, 0, 0});
      waitStrobe(n);
      chk("cause auto", {30'h0, refreshCause}, 32'h1);
      rc(8'h00, 32'h4, 2'h0);
      waitStrobe(n);
      waitStrobe(n);
      chk("auto gap", 32'(n), 32'(RC));
      rc(8'h44, 32'h105, 2'h0);
      wr(8'h40, 32'h0, r);
      // lane 0 masked: trigger and enable must not change
      @(posedge mclk);
      s_axi_wstrb <= 4'hE;
      wr(8'h40, 32'h3, r);
      chk("bresp masked", {30'h0, r}, 32'h0);
      rc(8'h40, 32'h0, 2'h0);
      rc(8'h44, 32'h5, 2'h0);
      // reset clears the count; control, already written to zero, still reads zero
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rc(8'h44, 32'h0, 2'h0);
      rc(8'h40, 32'h0, 2'h0);
      results();
   end
endmodule
